// File: host_bus_model.sv
`timescale 1ns/100ps
`default_nettype none
module host_bus_model (
  input  wire logic                      clk,
  output var  pmic_regs_pkg::regReq_type regReq,
  input  wire pmic_regs_pkg::regRsp_type regRsp
);
  import pmic_regs_pkg::*;

  initial regReq = '0;

  task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
    @(posedge clk);
    regReq <= '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
    @(posedge clk);
    // released lines show the inverse so a stale value is never trusted
    regReq <= '{wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: ~data};
  endtask : write_reg

  task automatic read_reg(input logic [7:0] addr, output logic [7:0] data, output logic ok);
    int n;
    @(posedge clk);
    regReq <= '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 8'h00};
    @(posedge clk);
    regReq <= '{wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: 8'hff};
    ok = 1'b0;
    data = 8'h00;
    // answer stands one cycle only, so look in every cycle of a short window
    for (n = 0; n < 4 && !ok; n++)
    begin
      @(negedge clk);
      if (regRsp.valid === 1'b1)
      begin
        data = regRsp.data;
        ok = 1'b1;
      end
    end
  endtask : read_reg
endmodule : host_bus_model
`default_nettype wire

// File: pmic_gpio_irq_control_regs.sv
// Notes on behaviour
// R1: LDO not-good bit reads 0 in range, 1 when low or disabled.
// R2: Hold bit ORed with button pin enables buck and LDO, else both off.
// R3: Button status bit shows debounced press, 1 meaning pressed.
// R4: Measure select picks battery at 0, temperature at 1; resets to 1.
// R5: Amplifier runs when its enable bit or charger power good is 1.
// R6: Reset delay select chooses 11 ms at 0, 90 ms at 1; resets to 1.
// R7: Pin state reads input buffer; output pins drive low on 0, float on 1.
// R8: LED-mode pins sink current on 0 and float on 1.
// R9: LED select bits of upper pins pick LED driver at 1; both reset 1.
// R10: Direction bit 0 is output, 1 is input; upper outputs, lower inputs.
// R11: Mask bit 1 suppresses its event, 0 allows it; all reset to 1.
// R12: First mask covers hot, cold, overvoltage, reserved, charger and loop events.
// R13: Second mask covers the eight charger state events.
// R14: Third mask covers pin changes, power good and button; bit 0 read-only.
// R15: First flags set on rising edges, charger active and power good on both.
// R16: Reset reloads every field default; all flags clear.
// R17: Flag reads 1 after an unmasked event and clears on read.
// R18: Comparator flag is held off while the comparator is disabled.
// R19: Interrupt output high while any unmasked flag remains set.
`timescale 1ns/100ps
`default_nettype none
module pmic_gpio_irq_control_regs #(
  parameter int RESET_DELAY_SHORT = pmic_regs_pkg::RESET_DELAY_SHORT_CYCLES,
  parameter int RESET_DELAY_LONG  = pmic_regs_pkg::RESET_DELAY_LONG_CYCLES
) (
  input  wire logic                       clk,
  input  wire logic                       reset,
  input  wire pmic_regs_pkg::regReq_type  regReq,
  output var  pmic_regs_pkg::regRsp_type  regRsp,
  input  wire pmic_regs_pkg::status_type  status,
  input  wire logic                       batteryCompEnable,
  input  wire logic [3:0]                 pinIn,
  output var  pmic_regs_pkg::pinDrive_type pinDrive,
  output logic                            supplyEnable,
  output logic                            measureSelect,
  output logic                            measureAmpEnable,
  output logic [pmic_regs_pkg::DELAY_WIDTH-1:0] resetDelayCycles,
  output logic                            irq
);
  import pmic_regs_pkg::*;

  typedef struct packed {
    logic                   hold;
    logic                   measureSel;
    logic                   ampBit;
    logic                   delaySel;
    logic [3:0]             pinData;
    logic [1:0]             ledSel;
    logic [3:0]             dir;
    logic [7:0]             mask0;
    logic [7:0]             mask1;
    logic [7:1]             mask2;
    logic [7:0]             flags;
    status_type             sts1;
    status_type             sts2;
    status_type             stsPrev;
    logic [3:0]             pin1;
    logic [3:0]             pin2;
    regRsp_type             rsp;
    pinDrive_type           drive;
    logic                   supply;
    logic                   ampOn;
    logic [DELAY_WIDTH-1:0] delayCount;
    logic                   irq;
  } state_type;

  state_type s_q;
  state_type s_d;

  logic [7:0] eventVec;
  logic [7:0] setVec;
  logic [7:0] clrVec;
  logic [3:0] ledVec;
  logic       outMode;
  logic       writeHit;
  logic       readHit;

  always_comb
  begin
    s_d      = s_q;
    eventVec = 8'h00;
    setVec   = 8'h00;
    clrVec   = 8'h00;
    ledVec   = 4'h0;
    outMode  = 1'b0;
    writeHit = regReq.wr;
    readHit  = regReq.rd;

    // second flop only reads the first; edges use the second and its delayed copy
    s_d.sts1    = status;
    s_d.sts2    = s_q.sts1;
    s_d.stsPrev = s_q.sts2;
    s_d.pin1    = pinIn;
    s_d.pin2    = s_q.pin1;

    if (writeHit)
    begin
      if (regReq.addr == POWER_CONTROL_ADDR)
      begin
        s_d.hold       = regReq.wdata[HOLD_BIT];
        // R4: measure select
        s_d.measureSel = regReq.wdata[MEASURE_SELECT_BIT];
        s_d.ampBit     = regReq.wdata[AMP_ENABLE_BIT];
        s_d.delaySel   = regReq.wdata[RESET_DELAY_BIT];
      end
      else if (regReq.addr == GPIO_PIN_STATE_ADDR)
      begin
        s_d.pinData = regReq.wdata[3:0];
      end
      else if (regReq.addr == GPIO_DIRECTION_ADDR)
      begin
        // R9: led select
        s_d.ledSel = regReq.wdata[LED_SELECT_LSB+1:LED_SELECT_LSB];
        s_d.dir    = regReq.wdata[3:0];
      end
      else if (regReq.addr == CHARGER_EVENT_MASK_ADDR)
      begin
        // R12: event mask
        s_d.mask0 = regReq.wdata;
      end
      else if (regReq.addr == CHARGER_STATE_MASK_ADDR)
      begin
        // R13: state mask
        s_d.mask1 = regReq.wdata;
      end
      else if (regReq.addr == GPIO_POWER_EVENT_MASK_ADDR)
      begin
        // R14: bit 0 not writable
        s_d.mask2 = regReq.wdata[7:1];
      end
    end

    // R15: edge sources
    eventVec[FLAG_HOT]    = s_q.sts2.thermistorHot & ~s_q.stsPrev.thermistorHot;
    eventVec[FLAG_COLD]   = s_q.sts2.thermistorCold & ~s_q.stsPrev.thermistorCold;
    eventVec[FLAG_OVER]   = s_q.sts2.overvoltageEvent & ~s_q.stsPrev.overvoltageEvent;
    eventVec[FLAG_ACTIVE] = s_q.sts2.chargerActive ^ s_q.stsPrev.chargerActive;
    eventVec[FLAG_PGOOD]  = s_q.sts2.chargerPowerGood ^ s_q.stsPrev.chargerPowerGood;
    eventVec[FLAG_COMP]   = s_q.sts2.batteryCompare & ~s_q.stsPrev.batteryCompare;
    eventVec[FLAG_LOOP]   = s_q.sts2.thermalLoop & ~s_q.stsPrev.thermalLoop;
    // R11: masked events never set
    setVec = eventVec & ~s_q.mask0 & FLAGS_IMPLEMENTED;
    // R18: comparator gated
    setVec[FLAG_COMP] = setVec[FLAG_COMP] & batteryCompEnable;
    // R17: read clears, a set in the same cycle wins
    if (readHit && regReq.addr == CHARGER_EVENT_FLAGS_ADDR)
    begin
      clrVec = 8'hff;
    end
    s_d.flags = (s_q.flags & ~clrVec) | setVec;
    if (!batteryCompEnable)
    begin
      s_d.flags[FLAG_COMP] = 1'b0;
    end

    s_d.rsp.valid = readHit;
    s_d.rsp.data  = 8'h00;
    if (readHit)
    begin
      if (regReq.addr == POWER_STATUS_ADDR)
      begin
        // R1: not-good levels
        s_d.rsp.data[BUCK_NOT_GOOD_BIT] = s_q.sts2.buckNotGood;
        s_d.rsp.data[LDO_NOT_GOOD_BIT]  = s_q.sts2.ldoNotGood;
      end
      else if (regReq.addr == POWER_CONTROL_ADDR)
      begin
        s_d.rsp.data[HOLD_BIT]           = s_q.hold;
        // R3: button status
        s_d.rsp.data[BUTTON_STATUS_BIT]  = s_q.sts2.buttonPressedStatus;
        s_d.rsp.data[MEASURE_SELECT_BIT] = s_q.measureSel;
        s_d.rsp.data[AMP_ENABLE_BIT]     = s_q.ampBit;
        s_d.rsp.data[RESET_DELAY_BIT]    = s_q.delaySel;
      end
      else if (regReq.addr == GPIO_PIN_STATE_ADDR)
      begin
        // R7: input buffer level
        s_d.rsp.data = {4'h0, s_q.pin2};
      end
      else if (regReq.addr == GPIO_DIRECTION_ADDR)
      begin
        s_d.rsp.data = {s_q.ledSel, 2'h3, s_q.dir};
      end
      else if (regReq.addr == CHARGER_EVENT_MASK_ADDR)
      begin
        s_d.rsp.data = s_q.mask0;
      end
      else if (regReq.addr == CHARGER_STATE_MASK_ADDR)
      begin
        s_d.rsp.data = s_q.mask1;
      end
      else if (regReq.addr == GPIO_POWER_EVENT_MASK_ADDR)
      begin
        s_d.rsp.data = {s_q.mask2, 1'b1};
      end
      else if (regReq.addr == CHARGER_EVENT_FLAGS_ADDR)
      begin
        s_d.rsp.data = s_q.flags;
      end
    end

    // open drain: pins only ever pull low, so the data line stays 0
    ledVec = {s_q.ledSel, 2'b00};
    s_d.drive.out = 4'h0;
    for (int i = 0; i < 4; i++)
    begin
      // R10: 0 is output
      outMode = ~s_q.dir[i];
      // R7: low on 0, float on 1
      s_d.drive.oe[i] = outMode & ~s_q.pinData[i] & ~ledVec[i];
    end
    // R8: led sink
    s_d.drive.ledSink = ~s_q.dir[3:2] & ~s_q.pinData[3:2] & s_q.ledSel;

    // R2: hold or button
    s_d.supply = s_q.hold | s_q.sts2.buttonInputPin;
    // R5: charger power good forces amplifier on
    s_d.ampOn  = s_q.ampBit | s_q.sts2.chargerPowerGood;
    // R6: delay choice
    s_d.delayCount = s_q.delaySel ? DELAY_WIDTH'(RESET_DELAY_LONG)
                                  : DELAY_WIDTH'(RESET_DELAY_SHORT);
    // R19: level follows unmasked flags
    s_d.irq = |(s_d.flags & ~s_d.mask0);
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      // R16: defaults
      s_q            <= '0;
      s_q.hold       <= POWER_CONTROL_RESET[HOLD_BIT];
      s_q.measureSel <= POWER_CONTROL_RESET[MEASURE_SELECT_BIT];
      s_q.ampBit     <= POWER_CONTROL_RESET[AMP_ENABLE_BIT];
      s_q.delaySel   <= POWER_CONTROL_RESET[RESET_DELAY_BIT];
      s_q.pinData    <= PIN_DATA_RESET;
      s_q.ledSel     <= LED_SELECT_RESET;
      s_q.dir        <= DIRECTION_RESET;
      s_q.mask0      <= MASK_RESET;
      s_q.mask1      <= MASK_RESET;
      s_q.mask2      <= MASK_RESET[7:1];
      s_q.flags      <= FLAGS_RESET;
      s_q.delayCount <= DELAY_WIDTH'(RESET_DELAY_LONG);
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign regRsp           = s_q.rsp;
  assign pinDrive         = s_q.drive;
  assign supplyEnable     = s_q.supply;
  assign measureSelect    = s_q.measureSel;
  assign measureAmpEnable = s_q.ampOn;
  assign resetDelayCycles = s_q.delayCount;
  assign irq              = s_q.irq;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  sequence s_ctrlWrite;
    regReq.wr && regReq.addr == POWER_CONTROL_ADDR;
  endsequence
  sequence s_flagRead;
    regReq.rd && regReq.addr == CHARGER_EVENT_FLAGS_ADDR;
  endsequence

  property p_ldoStatus;
    regReq.rd && regReq.addr == POWER_STATUS_ADDR
      |=> regRsp.valid && regRsp.data[LDO_NOT_GOOD_BIT] == $past(s_q.sts2.ldoNotGood);
  endproperty
  a_ldoStatus: assert property (p_ldoStatus) else $error("ldo status read wrong"); // R1

  property p_supply;
    s_ctrlWrite ##1 1'b1
      |=> supplyEnable == ($past(regReq.wdata[HOLD_BIT], 2) | $past(s_q.sts2.buttonInputPin));
  endproperty
  a_supply: assert property (p_supply) else $error("supply enable wrong"); // R2

  property p_measureSelect;
    s_ctrlWrite |=> measureSelect == $past(regReq.wdata[MEASURE_SELECT_BIT]);
  endproperty
  a_measureSelect: assert property (p_measureSelect) else $error("measure select not stored"); // R4

  property p_ampEnable;
    ##1 measureAmpEnable == ($past(s_q.ampBit) | $past(s_q.sts2.chargerPowerGood));
  endproperty
  a_ampEnable: assert property (p_ampEnable) else $error("amplifier enable wrong"); // R5

  property p_delay;
    s_ctrlWrite ##1 1'b1 |=> resetDelayCycles == ($past(regReq.wdata[RESET_DELAY_BIT], 2)
      ? DELAY_WIDTH'(RESET_DELAY_LONG) : DELAY_WIDTH'(RESET_DELAY_SHORT));
  endproperty
  a_delay: assert property (p_delay) else $error("reset delay wrong"); // R6

  property p_pinDrive;
    !s_q.dir[0] && !s_q.pinData[0] |=> pinDrive.oe[0];
  endproperty
  a_pinDrive: assert property (p_pinDrive) else $error("output pin not driven low"); // R7

  property p_ledSink;
    s_q.ledSel[1] && !s_q.dir[3] |=> pinDrive.ledSink[1] == !$past(s_q.pinData[3]) && !pinDrive.oe[3];
  endproperty
  a_ledSink: assert property (p_ledSink) else $error("led sink wrong"); // R8

  property p_maskBlocks;
    s_q.mask0[FLAG_HOT] && !s_q.flags[FLAG_HOT] |=> !s_q.flags[FLAG_HOT];
  endproperty
  a_maskBlocks: assert property (p_maskBlocks) else $error("masked event set a flag"); // R11

  property p_hotRise;
    s_q.sts2.thermistorHot && !s_q.stsPrev.thermistorHot && !s_q.mask0[FLAG_HOT]
      |=> s_q.flags[FLAG_HOT];
  endproperty
  a_hotRise: assert property (p_hotRise) else $error("hot edge lost"); // R15

  property p_readClear;
    (s_flagRead and setVec == 8'h00) |=> s_q.flags == 8'h00 && regRsp.valid;
  endproperty
  a_readClear: assert property (p_readClear) else $error("flags not cleared by read"); // R17

  property p_compOff;
    !batteryCompEnable |=> !s_q.flags[FLAG_COMP];
  endproperty
  a_compOff: assert property (p_compOff) else $error("comparator flag while disabled"); // R18

  property p_irq;
    irq == |(s_q.flags & ~s_q.mask0);
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt level mismatch"); // R19
endmodule : pmic_gpio_irq_control_regs
`default_nettype wire

// File: pmic_regs_pkg.sv
`default_nettype none
package pmic_regs_pkg;
  localparam logic [7:0] POWER_STATUS_ADDR          = 8'h09;
  localparam logic [7:0] POWER_CONTROL_ADDR         = 8'h0a;
  localparam logic [7:0] GPIO_PIN_STATE_ADDR        = 8'h0b;
  localparam logic [7:0] GPIO_DIRECTION_ADDR        = 8'h0c;
  localparam logic [7:0] CHARGER_EVENT_MASK_ADDR    = 8'h0d;
  localparam logic [7:0] CHARGER_STATE_MASK_ADDR    = 8'h0e;
  localparam logic [7:0] GPIO_POWER_EVENT_MASK_ADDR = 8'h0f;
  localparam logic [7:0] CHARGER_EVENT_FLAGS_ADDR   = 8'h10;

  localparam int BUCK_NOT_GOOD_BIT   = 6;
  localparam int LDO_NOT_GOOD_BIT    = 5;
  localparam int HOLD_BIT            = 5;
  localparam int BUTTON_STATUS_BIT   = 4;
  localparam int MEASURE_SELECT_BIT  = 2;
  localparam int AMP_ENABLE_BIT      = 1;
  localparam int RESET_DELAY_BIT     = 0;
  localparam int LED_SELECT_LSB      = 6;

  localparam int FLAG_HOT    = 7;
  localparam int FLAG_COLD   = 6;
  localparam int FLAG_OVER   = 5;
  localparam int FLAG_ACTIVE = 3;
  localparam int FLAG_PGOOD  = 2;
  localparam int FLAG_COMP   = 1;
  localparam int FLAG_LOOP   = 0;

  localparam logic [7:0] POWER_CONTROL_RESET  = 8'h05;
  localparam logic [3:0] PIN_DATA_RESET       = 4'hf;
  localparam logic [1:0] LED_SELECT_RESET     = 2'h3;
  localparam logic [3:0] DIRECTION_RESET      = 4'h3;
  localparam logic [7:0] MASK_RESET           = 8'hff;
  localparam logic [7:0] FLAGS_RESET          = 8'h00;
  localparam logic [7:0] FLAGS_IMPLEMENTED    = 8'hef;

  localparam int RESET_DELAY_SHORT_MS = 11;
  localparam int RESET_DELAY_LONG_MS  = 90;
  localparam int CLK_KHZ              = 100_000;
  localparam int DELAY_WIDTH          = 24;
  localparam int RESET_DELAY_SHORT_CYCLES = RESET_DELAY_SHORT_MS * CLK_KHZ;
  localparam int RESET_DELAY_LONG_CYCLES  = RESET_DELAY_LONG_MS * CLK_KHZ;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } regReq_type;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } regRsp_type;

  // analog and charger status levels, all asynchronous to clk
  typedef struct packed {
    logic ldoNotGood;
    logic buckNotGood;
    logic buttonInputPin;
    logic buttonPressedStatus;
    logic chargerPowerGood;
    logic chargerActive;
    logic thermistorHot;
    logic thermistorCold;
    logic overvoltageEvent;
    logic batteryCompare;
    logic thermalLoop;
  } status_type;

  typedef struct packed {
    logic [3:0] out;
    logic [3:0] oe;
    logic [1:0] ledSink;
  } pinDrive_type;
endpackage : pmic_regs_pkg
`default_nettype wire

// File: tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
  import pmic_regs_pkg::*;

  localparam logic [7:0] DEF_ADDR [7] = '{8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h0f, 8'h10};
  localparam logic [7:0] DEF_VAL  [7] = '{8'h05, 8'h06, 8'hf3, 8'hff, 8'hff, 8'hff, 8'h00};
  localparam int         EV_IDX   [7] = '{4, 3, 2, 1, 0, 5, 6};
  localparam int         EV_FLAG  [7] = '{FLAG_HOT, FLAG_COLD, FLAG_OVER, FLAG_COMP, FLAG_LOOP,
                                          FLAG_ACTIVE, FLAG_PGOOD};

  logic                   clk;
  logic                   reset;
  regReq_type             regReq;
  regRsp_type             regRsp;
  status_type             stat;
  logic                   compEn;
  logic [3:0]             pinIn;
  pinDrive_type           pinDrive;
  logic                   supplyEnable;
  logic                   measureSelect;
  logic                   measureAmpEnable;
  logic [DELAY_WIDTH-1:0] delayCycles;
  logic                   irq;
  logic [7:0]             rdata;
  logic                   ok;
  int                     bad_count;
  int                     n_compared;

  pmic_gpio_irq_control_regs #(.RESET_DELAY_SHORT(11), .RESET_DELAY_LONG(90)) uut (
    .clk(clk), .reset(reset), .regReq(regReq), .regRsp(regRsp), .status(stat),
    .batteryCompEnable(compEn), .pinIn(pinIn), .pinDrive(pinDrive),
    .supplyEnable(supplyEnable), .measureSelect(measureSelect),
    .measureAmpEnable(measureAmpEnable), .resetDelayCycles(delayCycles), .irq(irq)
  );

  host_bus_model host (.clk(clk), .regReq(regReq), .regRsp(regRsp));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic report_and_stop();
    $display("compared %0d, wrong %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : report_and_stop

  task automatic check(input logic [23:0] got, input logic [23:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    host.read_reg(a, rdata, ok);
    if (ok !== 1'b1)
    begin
      bad_count++;
      $display("wrong value at %0t: no answer from %h", $time, a);
      report_and_stop();
    end
    else
      check(24'(rdata), 24'(exp));
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host.write_reg(a, d);
  endtask : wr

  // sampling on the falling edge keeps clear of the launching edge
  task automatic wait_cycles(input int n);
    repeat (n) @(negedge clk);
  endtask : wait_cycles

  initial
  begin
    logic [7:0] e;
    logic [7:0] m;
    reset = 1'b1;
    stat = '0;
    compEn = 1'b1;
    pinIn = 4'h6;
    bad_count = 0;
    n_compared = 0;
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    wait_cycles(4);
    for (int i = 0; i < 7; i++) rd(DEF_ADDR[i], DEF_VAL[i]);
    check(24'(measureSelect), 24'h1);
    check(24'(delayCycles), 24'd90);
    check(24'(pinDrive), 24'h0);
    check(24'(supplyEnable), 24'h0);
    @(posedge clk) stat.ldoNotGood <= 1'b1;
    stat.buttonPressedStatus <= 1'b1;
    wait_cycles(5);
    rd(8'h09, 8'h20);
    rd(8'h0a, 8'h15);
    @(posedge clk) stat <= '0;
    wr(8'h0a, 8'h25);
    wait_cycles(4);
    check(24'(supplyEnable), 24'h1);
    wr(8'h0a, 8'h04);
    wait_cycles(4);
    check(24'(supplyEnable), 24'h0);
    check(24'(delayCycles), 24'd11);
    @(posedge clk) stat.buttonInputPin <= 1'b1;
    wait_cycles(5);
    check(24'(supplyEnable), 24'h1);
    wr(8'h0a, 8'h02);
    wait_cycles(3);
    check(24'(measureSelect), 24'h0);
    check(24'(measureAmpEnable), 24'h1);
    wr(8'h0a, 8'h00);
    wait_cycles(3);
    check(24'(measureAmpEnable), 24'h0);
    @(posedge clk) stat.chargerPowerGood <= 1'b1;
    wait_cycles(5);
    check(24'(measureAmpEnable), 24'h1);
    @(posedge clk) stat <= '0;
    wr(8'h0c, 8'h00);
    wr(8'h0b, 8'h05);
    wait_cycles(3);
    check(24'(pinDrive.oe), 24'ha);
    check(24'(pinDrive.ledSink), 24'h0);
    check(24'(pinDrive.out), 24'h0);
    rd(8'h0b, 8'h06);
    rd(8'h0c, 8'h30);
    wr(8'h0c, 8'hc0);
    wr(8'h0b, 8'h00);
    wait_cycles(3);
    check(24'(pinDrive.ledSink), 24'h3);
    check(24'(pinDrive.oe[1:0]), 24'h3);
    wr(8'h0b, 8'h0f);
    wait_cycles(3);
    check(24'(pinDrive.ledSink), 24'h0);
    wr(8'h0c, 8'hcf);
    wr(8'h0b, 8'h00);
    wait_cycles(3);
    check(24'(pinDrive), 24'h0);
    wr(8'h0e, 8'h5a);
    rd(8'h0e, 8'h5a);
    wr(8'h0f, 8'h5a);
    rd(8'h0f, 8'h5b);
    // two complementary masks show every event both masked and unmasked
    for (int k = 0; k < 2; k++)
    begin
      m = (k == 0) ? 8'h5a : 8'ha5;
      wr(8'h0d, m);
      rd(8'h0d, m);
      host.read_reg(8'h10, rdata, ok);
      for (int i = 0; i < 7; i++)
      begin
        e = (8'h01 << EV_FLAG[i]) & ~m;
        @(posedge clk) stat[EV_IDX[i]] <= 1'b1;
        wait_cycles(5);
        check(24'(irq), 24'(e != 8'h00));
        rd(8'h10, e);
        wait_cycles(1);
        check(24'(irq), 24'h0);
        rd(8'h10, 8'h00);
        @(posedge clk) stat[EV_IDX[i]] <= 1'b0;
        wait_cycles(5);
        rd(8'h10, (i >= 5) ? e : 8'h00);
      end
    end
    wr(8'h0d, 8'h00);
    @(posedge clk) compEn <= 1'b0;
    stat.batteryCompare <= 1'b1;
    wait_cycles(5);
    rd(8'h10, 8'h00);
    check(24'(irq), 24'h0);
    @(posedge clk) reset <= 1'b1;
    wait_cycles(3);
    @(posedge clk) reset <= 1'b0;
    wait_cycles(4);
    rd(8'h0d, 8'hff);
    rd(8'h0a, 8'h05);
    rd(8'h0c, 8'hf3);
    report_and_stop();
  end
endmodule : tb
`default_nettype wire
